// *** design/hdpa_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hdpa_defs.svh"

module hdpa_arbiter #(
    parameter int TICK_CYCLES = `HDPA_TICK_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    heatDemandIn,
    input  wire logic                    waterDemandIn,
    input  wire logic                    groupDemandIn,
    input  wire logic                    groupMasterIn,
    input  wire logic [`HDPA_ANN_W-1:0]  annunIn,
    input  wire logic                    heatEnable,
    input  wire logic                    waterEnable,
    input  wire logic                    groupSlaveEnable,
    input  wire logic                    waterOverGroup,
    input  wire logic                    waterOverHeat,
    input  wire logic [7:0]              overrideMin,
    input  wire logic [5:0]              overrideSec,
    input  wire logic                    derateEnable,
    input  wire logic signed [7:0]       outdoorTemp,
    input  wire logic                    annunEnable,
    input  wire logic                    burnerSwitch,
    input  wire logic                    antiShortCycle,
    input  wire logic                    configured,
    input  wire logic                    steamVariant,
    input  wire logic [1:0]              inletType,
    input  wire logic [1:0]              outletType,
    input  wire logic [1:0]              waterType,
    input  wire logic [1:0]              stackType,
    input  wire logic [1:0]              outdoorType,
    output logic                         burnerDemand,
    output var hdpa_pkg::hdpa_src_t      activeSource,
    output logic                         waterOverrideActive,
    output logic [15:0]                  overrideRemain,
    output logic [`HDPA_ANN_W-1:0]       annunOut,
    output logic [2:0]                   safetyVerifyReq,
    output logic                         sensorCfgValid,
    output logic                         burnerLockout,
    output logic                         safetyOutEnable
);

    localparam int PIN_W = 4 + `HDPA_ANN_W;

    hdpa_pkg::hdpa_state_t st_q;
    hdpa_pkg::hdpa_state_t st_d;
    logic [PIN_W-1:0]      pinSync;
    logic [15:0]           effSec;
    logic                  heatSync;
    logic                  waterSync;
    logic                  groupSync;
    logic                  masterSync;
    logic [`HDPA_ANN_W-1:0] annunSync;
    logic                  groupControl;
    logic                  heatReq;
    logic                  groupReq;
    logic                  waterReq;
    logic                  overrideNow;
    logic                  waterBeatsGroup;
    logic                  waterBeatsHeat;
    logic                  tickNow;
    logic                  inletOk;
    logic                  limitsOk;
    logic                  outdoorOk;
    hdpa_pkg::hdpa_src_t   winner;

    hdpa_sync #(
        .W (PIN_W)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({heatDemandIn, waterDemandIn, groupDemandIn, groupMasterIn, annunIn}),
        .dout (pinSync)
    );

    hdpa_derate u_derate (
        .clk         (clk),
        .nrst        (nrst),
        .derateEnable (derateEnable),
        .outdoorTemp (outdoorTemp),
        .overrideMin (overrideMin),
        .overrideSec (overrideSec),
        .effSec      (effSec)
    );

    assign {heatSync, waterSync, groupSync, masterSync, annunSync} = pinSync;

    assign groupControl    = groupSlaveEnable && masterSync;
    assign groupReq        = groupControl && groupSync;
    assign heatReq         = heatEnable && heatSync && !groupControl;
    // Steam units have no domestic water loop
    assign waterReq        = waterEnable && !steamVariant && waterSync;
    assign overrideNow     = waterReq && (st_q.timer != 16'h0000);
    // Override only adds wins; a setting that already wins stays untouched
    assign waterBeatsGroup = waterOverGroup || overrideNow;
    assign waterBeatsHeat  = waterOverHeat || overrideNow;
    assign tickNow     = (st_q.tick == 26'(TICK_CYCLES - 1));

    always_comb
    begin
        if (waterReq && (!groupReq || waterBeatsGroup) && (!heatReq || waterBeatsHeat))
        begin
            winner = hdpa_pkg::SRC_WATER;
        end
        else if (groupReq)
        begin
            winner = hdpa_pkg::SRC_GROUP;
        end
        else if (heatReq)
        begin
            winner = hdpa_pkg::SRC_HEAT;
        end
        else
        begin
            winner = hdpa_pkg::SRC_NONE;
        end
    end

    always_comb
    begin
        inletOk = 1'b0;
        if (inletType == `HDPA_INLET_LOW || inletType == `HDPA_INLET_HIGH)
        begin
            inletOk = 1'b1;
        end
        limitsOk  = (outletType != `HDPA_LIM_NONE) && (waterType != `HDPA_LIM_NONE)
                    && (stackType != `HDPA_LIM_NONE);
        outdoorOk = steamVariant ? (outdoorType == `HDPA_OD_NONE)
                    : (outdoorType == `HDPA_OD_10K || outdoorType == `HDPA_OD_12K);
    end

    always_comb
    begin
        st_d = st_q;
        st_d.waterPrev = waterReq;
        st_d.tick      = tickNow ? 26'h0000000 : st_q.tick + 26'h0000001;
        if (!waterReq)
        begin
            st_d.timer = `HDPA_TIMER_RST;
        end
        else if (!st_q.waterPrev)
        begin
            st_d.timer = effSec;
        end
        else if (tickNow && st_q.timer != 16'h0000)
        begin
            st_d.timer = st_q.timer - 16'h0001;
        end
        st_d.sel = winner;
        st_d.ovr = overrideNow;
        // Anti short cycle holds off everything but a winning domestic water call
        st_d.burner = configured && burnerSwitch && (winner != hdpa_pkg::SRC_NONE)
                      && (!antiShortCycle || winner == hdpa_pkg::SRC_WATER);
        st_d.annun    = annunEnable ? annunSync : '0;
        st_d.verify   = {stackType == `HDPA_LIM_DUAL10K, waterType == `HDPA_LIM_DUAL10K,
                         outletType == `HDPA_LIM_DUAL10K};
        st_d.cfgOk    = inletOk && limitsOk && outdoorOk;
        st_d.lockout  = !configured;
        st_d.safetyEn = configured;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q         <= '0;
            st_q.lockout <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign burnerDemand      = st_q.burner;
    assign activeSource      = st_q.sel;
    assign waterOverrideActive = st_q.ovr;
    assign overrideRemain    = st_q.timer;
    assign annunOut          = st_q.annun;
    assign safetyVerifyReq   = st_q.verify;
    assign sensorCfgValid    = st_q.cfgOk;
    assign burnerLockout     = st_q.lockout;
    assign safetyOutEnable   = st_q.safetyEn;

    property p_ch_ignored;
        @(posedge clk) disable iff (!nrst)
        groupControl |=> activeSource != hdpa_pkg::SRC_HEAT;
    endproperty
    a_ch_ignored: assert property (p_ch_ignored)
        else $error("central heat selected under lead/lag master");

    property p_prio_setting;
        @(posedge clk) disable iff (!nrst)
        (waterReq && !overrideNow && groupReq && !waterOverGroup)
        |=> activeSource == hdpa_pkg::SRC_GROUP;
    endproperty
    a_prio_setting: assert property (p_prio_setting)
        else $error("domestic water beat lead/lag without priority");

    property p_override_wins;
        @(posedge clk) disable iff (!nrst)
        overrideNow |=> activeSource == hdpa_pkg::SRC_WATER && waterOverrideActive;
    endproperty
    a_override_wins: assert property (p_override_wins)
        else $error("override did not give domestic water priority");

    property p_normal_wins;
        @(posedge clk) disable iff (!nrst)
        (waterReq && waterOverGroup && waterOverHeat) |=> activeSource == hdpa_pkg::SRC_WATER;
    endproperty
    a_normal_wins: assert property (p_normal_wins)
        else $error("domestic water lost despite top normal priority");

    property p_timer_clear;
        @(posedge clk) disable iff (!nrst)
        !waterReq |=> overrideRemain == 16'h0000 ##1 !waterOverrideActive;
    endproperty
    a_timer_clear: assert property (p_timer_clear)
        else $error("override timer not cleared on demand loss");

    property p_timer_load;
        @(posedge clk) disable iff (!nrst)
        (waterReq && !st_q.waterPrev) |=> overrideRemain == $past(effSec);
    endproperty
    a_timer_load: assert property (p_timer_load)
        else $error("override timer not loaded on demand rise");

    property p_timer_hold;
        @(posedge clk) disable iff (!nrst)
        (waterReq && st_q.waterPrev && !tickNow) |=> $stable(overrideRemain);
    endproperty
    a_timer_hold: assert property (p_timer_hold)
        else $error("override timer moved between seconds");

    property p_annun_off;
        @(posedge clk) disable iff (!nrst)
        !annunEnable |=> annunOut == '0;
    endproperty
    a_annun_off: assert property (p_annun_off)
        else $error("annunciator input passed while disabled");

    property p_burner_switch;
        @(posedge clk) disable iff (!nrst)
        !burnerSwitch |=> !burnerDemand;
    endproperty
    a_burner_switch: assert property (p_burner_switch)
        else $error("burner fired with switch off");

    property p_unconfigured;
        @(posedge clk) disable iff (!nrst)
        !configured |=> burnerLockout && !safetyOutEnable && !burnerDemand;
    endproperty
    a_unconfigured: assert property (p_unconfigured)
        else $error("unconfigured unit not locked out");

    property p_asc;
        @(posedge clk) disable iff (!nrst)
        (antiShortCycle && winner != hdpa_pkg::SRC_WATER) |=> !burnerDemand;
    endproperty
    a_asc: assert property (p_asc)
        else $error("anti short cycle bypassed by non-priority demand");

    property p_verify;
        @(posedge clk) disable iff (!nrst)
        (outletType == `HDPA_LIM_DUAL10K) |=> safetyVerifyReq[0];
    endproperty
    a_verify: assert property (p_verify)
        else $error("dual outlet sensor not flagged for verification");

    property p_inlet_unset;
        @(posedge clk) disable iff (!nrst)
        (inletType == `HDPA_INLET_NONE) |=> !sensorCfgValid;
    endproperty
    a_inlet_unset: assert property (p_inlet_unset)
        else $error("unconfigured inlet type accepted as valid");

endmodule // hdpa_arbiter

`default_nettype wire

// *** design/hdpa_defs.svh ***
`ifndef HDPA_DEFS_SVH
`define HDPA_DEFS_SVH

// Timing
`define HDPA_CLK_HZ          50000000
`define HDPA_TICK_S          1
`define HDPA_TICK_CYCLES     (`HDPA_CLK_HZ * `HDPA_TICK_S)
`define HDPA_SEC_PER_MIN     16'h003C

// Outdoor derate thresholds in whole degrees F
`define HDPA_DERATE_HIGH_F   8'sh20
`define HDPA_DERATE_LOW_F    -8'sh28
`define HDPA_DERATE_SPAN_F   24'h000048

// Sensor type codes
`define HDPA_INLET_NONE      2'h0
`define HDPA_INLET_LOW       2'h1
`define HDPA_INLET_HIGH      2'h2
`define HDPA_LIM_NONE        2'h0
`define HDPA_LIM_DUAL10K     2'h1
`define HDPA_LIM_SINGLE10K   2'h2
`define HDPA_LIM_SINGLE12K   2'h3
`define HDPA_OD_NONE         2'h0
`define HDPA_OD_10K          2'h1
`define HDPA_OD_12K          2'h2

// Widths and reset values
`define HDPA_ANN_W           8
`define HDPA_TIMER_RST       16'h0000

`endif

// *** design/hdpa_pkg.sv ***
package hdpa_pkg;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_HEAT,
        SRC_GROUP,
        SRC_WATER
    } hdpa_src_t;

    typedef struct packed {
        logic [15:0] timer;
        logic [25:0] tick;
        logic        waterPrev;
        hdpa_src_t   sel;
        logic        burner;
        logic        ovr;
        logic [7:0]  annun;
        logic [2:0]  verify;
        logic        cfgOk;
        logic        lockout;
        logic        safetyEn;
    } hdpa_state_t;

endpackage

// *** design/hdpa_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module hdpa_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hdpa_sync_t;

    hdpa_sync_t st_q;
    hdpa_sync_t st_d;

    always_comb
    begin
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

endmodule // hdpa_sync

`default_nettype wire

// *** design/hdpa_derate.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hdpa_defs.svh"

module hdpa_derate (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              derateEnable,
    input  wire logic signed [7:0] outdoorTemp,
    input  wire logic        [7:0] overrideMin,
    input  wire logic        [5:0] overrideSec,
    output logic             [15:0] effSec
);

    typedef struct packed {
        logic [15:0] eff;
    } hdpa_derate_t;

    hdpa_derate_t st_q;
    hdpa_derate_t st_d;
    logic [15:0]  progSec;
    logic [23:0]  scaled;
    logic [7:0]   offset;

    assign progSec = 16'(overrideMin * `HDPA_SEC_PER_MIN) + {10'h000, overrideSec};
    assign offset  = 8'(outdoorTemp - `HDPA_DERATE_LOW_F);

    always_comb
    begin
        scaled = '0;
        if (!derateEnable || outdoorTemp >= `HDPA_DERATE_HIGH_F)
        begin
            st_d.eff = progSec;
        end
        else if (outdoorTemp <= `HDPA_DERATE_LOW_F)
        begin
            st_d.eff = 16'h0000;
        end
        else
        begin
            // Truncating divide: never grants more override than the line allows
            scaled   = ({8'h00, progSec} * {16'h0000, offset}) / `HDPA_DERATE_SPAN_F;
            st_d.eff = scaled[15:0];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign effSec = st_q.eff;

    property p_derate_full;
        @(posedge clk) disable iff (!nrst)
        (!derateEnable || outdoorTemp >= `HDPA_DERATE_HIGH_F) |=> effSec == $past(progSec);
    endproperty
    a_derate_full: assert property (p_derate_full)
        else $error("override time derated above upper threshold");

    property p_derate_zero;
        @(posedge clk) disable iff (!nrst)
        (derateEnable && outdoorTemp <= `HDPA_DERATE_LOW_F) |=> effSec == 16'h0000;
    endproperty
    a_derate_zero: assert property (p_derate_zero)
        else $error("override time not zero at lower threshold");

    property p_derate_mid;
        @(posedge clk) disable iff (!nrst)
        (derateEnable && outdoorTemp > `HDPA_DERATE_LOW_F && outdoorTemp < `HDPA_DERATE_HIGH_F)
        |=> effSec <= $past(progSec);
    endproperty
    a_derate_mid: assert property (p_derate_mid)
        else $error("derated time exceeds programmed time");

endmodule // hdpa_derate

`default_nettype wire

// *** testbench/hdpa_demand_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Far side: the heat demand contacts, the lead/lag master and the annunciator
// contacts. Pins change on the falling edge after a request, off-phase from the design's
// own sampling, so the synchronisers see a genuine asynchronous edge.
module hdpa_demand_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       reqHeat,
    input  wire logic       reqWater,
    input  wire logic       reqGroup,
    input  wire logic [7:0] reqAnn,
    output logic            heatPin,
    output logic            waterPin,
    output logic            groupPin,
    output logic            masterPin,
    output logic      [7:0] annPin
);
    always_ff @(negedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {heatPin, waterPin, groupPin, masterPin, annPin} <= '0;
        end
        else
        begin
            heatPin  <= reqHeat;
            waterPin <= reqWater;
            groupPin <= reqGroup;
            // The master only takes control while it has a group demand to serve
            masterPin <= reqGroup;
            annPin <= reqAnn;
        end
    end
endmodule // hdpa_demand_model

`default_nettype wire

// *** testbench/tb_heat_demand_priority_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_heat_demand_priority_arbiter;
    localparam int TICK = 8;
    localparam int LIMIT = 6000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic heatEnable, waterEnable, groupSlaveEnable, waterOverGroup, waterOverHeat, derateEnable;
    logic annunEnable, burnerSwitch, antiShortCycle, configured, steamVariant;
    logic [7:0] overrideMin;
    logic [5:0] overrideSec;
    logic signed [7:0] outdoorTemp;
    logic [1:0] inletType, outletType, waterType, stackType, outdoorType;
    logic reqHeat, reqWater, reqGroup;
    logic [7:0] reqAnn;
    wire logic heatDemandIn, waterDemandIn, groupDemandIn, groupMasterIn;
    wire logic [7:0] annunIn;
    logic burnerDemand, waterOverrideActive, sensorCfgValid, burnerLockout, safetyOutEnable;
    hdpa_pkg::hdpa_src_t activeSource;
    logic [15:0] overrideRemain;
    logic [7:0] annunOut;
    logic [2:0] safetyVerifyReq;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hAA9F5E4E;
    logic [31:0] r;
    logic signed [7:0] temps [9] = '{100, 32, 31, 0, -4, -22, -39, -40, -40};

    always #10 clk = ~clk;

    hdpa_demand_model model (.clk, .nrst, .reqHeat, .reqWater, .reqGroup, .reqAnn,
        .heatPin(heatDemandIn), .waterPin(waterDemandIn), .groupPin(groupDemandIn),
        .masterPin(groupMasterIn), .annPin(annunIn));

    hdpa_arbiter #(.TICK_CYCLES(TICK)) dut (.clk, .nrst, .heatDemandIn, .waterDemandIn,
        .groupDemandIn, .groupMasterIn, .annunIn, .heatEnable, .waterEnable,
        .groupSlaveEnable, .waterOverGroup, .waterOverHeat, .overrideMin, .overrideSec,
        .derateEnable, .outdoorTemp, .annunEnable, .burnerSwitch, .antiShortCycle,
        .configured, .steamVariant, .inletType, .outletType, .waterType, .stackType,
        .outdoorType, .burnerDemand, .activeSource, .waterOverrideActive, .overrideRemain,
        .annunOut, .safetyVerifyReq, .sensorCfgValid, .burnerLockout, .safetyOutEnable);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Ranking with the timer override forced off; master control follows reqGroup
    function automatic hdpa_pkg::hdpa_src_t exp_src();
        logic gp, ht, wt;
        gp = groupSlaveEnable & reqGroup;
        ht = heatEnable & reqHeat & !(groupSlaveEnable & reqGroup);
        wt = waterEnable & reqWater & !steamVariant;
        if (wt && (!gp || waterOverGroup) && (!ht || waterOverHeat))
            return hdpa_pkg::SRC_WATER;
        if (gp)
            return hdpa_pkg::SRC_GROUP;
        if (ht)
            return hdpa_pkg::SRC_HEAT;
        return hdpa_pkg::SRC_NONE;
    endfunction

    function automatic logic [15:0] exp_eff(input logic signed [7:0] t);
        int prog;
        prog = int'(overrideMin) * 60 + int'(overrideSec);
        if (!derateEnable || t >= 32)
            return 16'(prog);
        if (t <= -40)
            return 16'h0000;
        return 16'(prog * (int'(t) + 40) / 72);
    endfunction

    // Every type must be set; steam forbids an outdoor sensor, hydronic needs one
    function automatic logic exp_valid();
        logic inOk, odOk;
        inOk = (inletType == 2'h1) || (inletType == 2'h2);
        odOk = steamVariant ? (outdoorType == 2'h0)
            : (outdoorType == 2'h1 || outdoorType == 2'h2);
        return inOk && odOk && outletType != 2'h0 && waterType != 2'h0 && stackType != 2'h0;
    endfunction

    task automatic report(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        report({15'h0000, g}, {15'h0000, e});
    endtask

    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        report(g, e);
    endtask

    task automatic cmpSrc(input hdpa_pkg::hdpa_src_t g, input hdpa_pkg::hdpa_src_t e);
        report({14'h0000, g}, {14'h0000, e});
    endtask

    // A free-running tick may already have taken one second off the loaded value
    task automatic cmpRemain(input logic [15:0] e);
        cmp16((e != 16'h0000 && overrideRemain === e - 16'h0001) ? e : overrideRemain, e);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic base_cfg(input logic oc, input logic [5:0] sec);
        {heatEnable, waterEnable, configured, burnerSwitch} <= 4'hF;
        {groupSlaveEnable, waterOverGroup, derateEnable, antiShortCycle, steamVariant} <= 5'h00;
        waterOverHeat <= oc;
        overrideMin <= 8'h00;
        overrideSec <= sec;
    endtask

    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        {heatEnable, waterEnable, groupSlaveEnable, waterOverGroup, waterOverHeat} = '0;
        derateEnable = 1'b0;
        {annunEnable, burnerSwitch, antiShortCycle, configured, steamVariant} = '0;
        {overrideMin, overrideSec, outdoorTemp} = '0;
        {inletType, outletType, waterType, stackType, outdoorType} = '0;
        {reqHeat, reqWater, reqGroup, reqAnn} = '0;
        step(6);
        cmp1(burnerLockout, 1'b1);
        cmp1(safetyOutEnable, 1'b0);
        nrst <= 1'b1;
        step(6);
        cmp1(burnerDemand, 1'b0);
        $display("Test reset done");

        for (int oc = 0; oc < 2; oc++)
        begin
            base_cfg(oc[0], 6'h03);
            reqHeat <= 1'b1;
            step(6);
            cmpSrc(activeSource, hdpa_pkg::SRC_HEAT);
            reqWater <= 1'b1;
            step(6);
            cmpSrc(activeSource, hdpa_pkg::SRC_WATER);
            if (oc == 0)
                cmp1(waterOverrideActive, 1'b1);
            reqWater <= 1'b0;
            step(6);
            cmp16(overrideRemain, 16'h0000);
            cmp1(waterOverrideActive, 1'b0);
            reqWater <= 1'b1;
            step(6);
            cmpRemain(16'h0003);
            step(40);
            cmpSrc(activeSource, oc ? hdpa_pkg::SRC_WATER : hdpa_pkg::SRC_HEAT);
            cmp1(waterOverrideActive, 1'b0);
            cmp1(burnerDemand, 1'b1);
            {reqWater, reqHeat} <= 2'b00;
            step(6);
        end
        $display("Test override done");

        base_cfg(1'b0, 6'h00);
        overrideMin <= 8'h01;
        for (int i = 0; i < 9; i++)
        begin
            derateEnable <= (i < 8);
            outdoorTemp <= temps[i];
            step(4);
            reqWater <= 1'b1;
            step(6);
            cmpRemain(exp_eff(temps[i]));
            cmp1(waterOverrideActive, exp_eff(temps[i]) != 16'h0000);
            reqWater <= 1'b0;
            step(6);
        end
        $display("Test derate done");

        base_cfg(1'b0, 6'h00);
        antiShortCycle <= 1'b1;
        {reqHeat, reqWater} <= 2'b11;
        step(6);
        cmpSrc(activeSource, hdpa_pkg::SRC_HEAT);
        cmp1(burnerDemand, 1'b0);
        waterOverHeat <= 1'b1;
        step(6);
        cmpSrc(activeSource, hdpa_pkg::SRC_WATER);
        cmp1(burnerDemand, 1'b1);
        {reqHeat, reqWater} <= 2'b00;
        antiShortCycle <= 1'b0;
        step(6);
        $display("Test short cycle done");

        for (int k = 0; k < 60; k++)
        begin
            r = rnd();
            {heatEnable, waterEnable, groupSlaveEnable, waterOverGroup, waterOverHeat} <= r[4:0];
            {annunEnable, burnerSwitch, configured} <= {r[5], r[6], r[7] | r[8]};
            steamVariant <= &r[10:9];
            {reqHeat, reqWater, reqGroup} <= r[13:11];
            reqAnn <= r[21:14];
            inletType <= r[23:22] | 2'h1;
            outletType <= r[25:24] | 2'h1;
            waterType <= r[27:26] | 2'h1;
            stackType <= r[29:28] | 2'h1;
            outdoorType <= r[31:30];
            step(7);
            cmpSrc(activeSource, exp_src());
            cmp1(burnerDemand, configured & burnerSwitch & (exp_src() != hdpa_pkg::SRC_NONE));
            cmp1(burnerLockout, !configured);
            cmp1(safetyOutEnable, configured);
            cmp16({8'h00, annunOut}, {8'h00, annunEnable ? reqAnn : 8'h00});
            cmp16({13'h0000, safetyVerifyReq},
                {13'h0000, stackType == 2'h1, waterType == 2'h1, outletType == 2'h1});
            cmp1(sensorCfgValid, exp_valid());
        end
        $display("Test random done");
        final_report();
    end
endmodule // tb_heat_demand_priority_arbiter

`default_nettype wire
